// ### hdl/ddi_regs.sv
/*
 * Debug instruction register bank: APB slave holding the two debug
 * instruction registers, the debug command and status registers and the
 * tie-off configuration report, plus the dispatcher that hands a stored
 * instruction to the execution engine.
 * Assumes an APB master on CLK and an engine that pulses EXEC_DONE once
 * per launched instruction.
 */
// Behaviour
// R01 - Low register: byte1 top, byte0 below
// R02 - Three-bit binary channel field selects channel
// R03 - Bit zero: manager thread or channel thread
// R04 - Channel thread uses channel field as target
// R05 - Software writes zeros into reserved bits
// R06 - High register holds bytes two to five
// R07 - Configuration register reports tie-off values
// R08 - Command code zero executes stored instruction
// R09 - Status bit: zero idle, one busy
// R10 - Instruction registers hold until rewritten
`timescale 1ns/1ps

module ddi_regs
(
	CLK,
	RST_B,
	PSEL,
	PENABLE,
	PWRITE,
	PADDR,
	PWDATA,
	PRDATA,
	PREADY,
	PSLVERR,
	TIEOFF,
	BOOT_MGR_NS,
	BOOT_FROM_PC,
	EXEC_VALID,
	EXEC_CMD,
	EXEC_MGR_SEL,
	EXEC_CHAN_SEL,
	EXEC_DONE
);
	input  wire logic                    CLK;
	input  wire logic                    RST_B;
	input  wire logic                    PSEL;
	input  wire logic                    PENABLE;
	input  wire logic                    PWRITE;
	input  wire logic [11:0]             PADDR;
	input  wire logic [31:0]             PWDATA;
	output logic      [31:0]             PRDATA;
	output logic                         PREADY;
	output logic                         PSLVERR;
	input  wire ddi_pkg::ddi_tieoff_type TIEOFF;
	input  wire logic                    BOOT_MGR_NS;
	input  wire logic                    BOOT_FROM_PC;
	output logic                         EXEC_VALID;
	output ddi_pkg::ddi_instr_type       EXEC_CMD;
	output logic                         EXEC_MGR_SEL;
	output logic      [7:0]              EXEC_CHAN_SEL;
	input  wire logic                    EXEC_DONE;

	////////////////////////////////////////////////////////////////////////
	// Decode.

	ddi_pkg::ddi_instr_type instr;      // Held instruction and target.
	ddi_pkg::ddi_state_type state;      // Dispatcher state.
	logic                   boot_seen;  // Boot straps already captured.
	logic                   mgr_ns;     // Boot strap captured after reset.
	logic                   boot_en;    // Boot strap captured after reset.
	logic [7:0]             next_chan;  // One-hot channel target; all zero for a manager thread.
	logic [31:0]            cfg_word;   // Assembled configuration word.
	logic [31:0]            rd_word;    // Read data selected by address.

	wire setup   = PSEL && !PENABLE;         // First APB cycle.
	wire access  = PSEL && PENABLE;          // Second APB cycle.
	wire hit_st  = PADDR == ddi_pkg::OFF_STATUS;
	wire hit_cmd = PADDR == ddi_pkg::OFF_COMMAND;
	wire hit_lo  = PADDR == ddi_pkg::OFF_INSTR_LO;
	wire hit_hi  = PADDR == ddi_pkg::OFF_INSTR_HI;
	wire hit_cfg = PADDR == ddi_pkg::OFF_CONFIG;
	wire mapped  = hit_st || hit_cmd || hit_lo || hit_hi || hit_cfg;
	wire wr_lo   = access && PWRITE && hit_lo;
	wire wr_hi   = access && PWRITE && hit_hi;
	// Reserved command codes and commands while busy are dropped.
	wire launch  = access && PWRITE && hit_cmd && state == ddi_pkg::ST_IDLE
		&& PWDATA[1:0] == ddi_pkg::CMD_EXECUTE; // [R08]
	wire busy    = state == ddi_pkg::ST_BUSY;

	// Zero-wait slave; unmapped addresses answer with an error.
	assign PREADY  = 1'b1;
	assign PSLVERR = access && !mapped;

	// Tie-offs are packed into their report fields.
	always_comb
	begin
		cfg_word = ddi_pkg::WORD_ZERO;
		cfg_word[ddi_pkg::CFG_PERIPH_BIT] = TIEOFF.periph_en; // [R07]
		cfg_word[ddi_pkg::CFG_BOOT_EN_BIT] = boot_en;
		cfg_word[ddi_pkg::CFG_MGR_NS_BIT] = mgr_ns;
		cfg_word[ddi_pkg::CFG_CHNLS_LSB +: 3] = TIEOFF.num_chnls; // [R07]
		cfg_word[ddi_pkg::CFG_PERIPH_LSB +: 5] = TIEOFF.num_periph; // [R07]
		cfg_word[ddi_pkg::CFG_EVENTS_LSB +: 5] = TIEOFF.num_events; // [R07]
	end

	// Write-only registers read as zero, so only status and config show.
	always_comb
	begin
		rd_word = ddi_pkg::WORD_ZERO;
		if (hit_st)
		begin
			rd_word[0] = busy; // [R09]
		end
		else if (hit_cfg)
		begin
			rd_word = cfg_word;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers.

	// Read data is sampled in the setup cycle so it comes from a flop.
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			PRDATA <= ddi_pkg::WORD_ZERO;
		else if (setup && !PWRITE)
			PRDATA <= rd_word;
	end

	// Straps are caught on the first edge after reset release; an async
	// reset may only load constants, so the capture is clocked.
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			boot_seen <= 1'b0;
			mgr_ns    <= 1'b0;
			boot_en   <= 1'b0;
		end
		else if (!boot_seen)
		begin
			boot_seen <= 1'b1;
			mgr_ns    <= BOOT_MGR_NS;
			boot_en   <= BOOT_FROM_PC;
		end
	end

	// Reserved bits are not stored; software is expected to write them
	// as zero, and a nonzero value there has no effect. [R05]
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			instr <= '0;
		end
		else
		begin
			if (wr_lo) // [R10]
			begin
				instr.byte1   <= PWDATA[ddi_pkg::LO_BYTE1_MSB:
					ddi_pkg::LO_BYTE1_LSB]; // [R01]
				instr.byte0   <= PWDATA[ddi_pkg::LO_BYTE0_MSB:
					ddi_pkg::LO_BYTE0_LSB]; // [R01]
				instr.channel <= PWDATA[ddi_pkg::LO_CHAN_MSB:
					ddi_pkg::LO_CHAN_LSB]; // [R02]
				instr.thread  <= PWDATA[ddi_pkg::LO_THREAD_BIT]; // [R03]
			end
			if (wr_hi) // [R10]
			begin
				{instr.byte5, instr.byte4, instr.byte3, instr.byte2}
					<= PWDATA; // [R06]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Dispatcher.

	// Channel target decode, one bit per channel.
	genvar gi;
	generate
		for (gi = 0; gi < ddi_pkg::NUM_CHAN; gi = gi + 1)
		begin : g_chan
			assign next_chan[gi] = instr.thread
				&& instr.channel == 3'(gi); // [R04]
		end
	endgenerate

	// Launch copies the instruction so later register writes cannot
	// disturb an instruction the engine is still working on.
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			state         <= ddi_pkg::ST_IDLE;
			EXEC_VALID    <= 1'b0;
			EXEC_CMD      <= '0;
			EXEC_MGR_SEL  <= 1'b0;
			EXEC_CHAN_SEL <= 8'h00;
		end
		else
		begin
			EXEC_VALID <= launch;
			if (launch)
			begin
				state         <= ddi_pkg::ST_BUSY; // [R09]
				EXEC_CMD      <= instr; // [R08]
				EXEC_MGR_SEL  <= !instr.thread; // [R03]
				EXEC_CHAN_SEL <= next_chan; // [R04]
			end
			else if (busy && EXEC_DONE)
			begin
				state <= ddi_pkg::ST_IDLE; // [R09]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	instr_low_a: assert property (wr_lo |=> instr.byte1 == // [R01]
		$past(PWDATA[31:24]) && instr.byte0 == $past(PWDATA[23:16]))
		else $error("Low instruction bytes not stored in place.");
	chan_field_a: assert property (wr_lo |=> // [R02]
		instr.channel == $past(PWDATA[10:8]))
		else $error("Channel field not stored.");
	thread_bit_a: assert property (launch |=> // [R03]
		EXEC_MGR_SEL == !$past(instr.thread))
		else $error("Manager select does not follow thread bit.");
	chan_sel_a: assert property (EXEC_VALID |-> EXEC_CHAN_SEL == // [R04]
		(EXEC_CMD.thread ? (ddi_pkg::CHAN_ONE << EXEC_CMD.channel)
		: 8'h00))
		else $error("Channel target does not match channel field.");
	instr_high_a: assert property (wr_hi |=> instr.byte2 == // [R06]
		$past(PWDATA[7:0]) && instr.byte5 == $past(PWDATA[31:24]))
		else $error("High instruction bytes not stored in place.");
	cfg_read_a: assert property (setup && !PWRITE && hit_cfg |=> // [R07]
		PRDATA[6:4] == $past(TIEOFF.num_chnls)
		&& PRDATA[21:17] == $past(TIEOFF.num_events))
		else $error("Configuration read does not show tie-offs.");
	exec_start_a: assert property (launch |=> EXEC_VALID && busy // [R08]
		&& EXEC_CMD == $past(instr))
		else $error("Execute command did not launch instruction.");
	status_read_a: assert property (setup && !PWRITE && hit_st |=> // [R09]
		PRDATA[0] == $past(busy))
		else $error("Status bit does not show busy state.");
	instr_hold_a: assert property (!wr_lo && !wr_hi |=> // [R10]
		$stable(instr))
		else $error("Instruction changed without a write.");

	// Covers for the main scenarios: both thread kinds, a refused
	// execute while busy, and an unmapped access.
	mgr_launch_c: cover property (launch && !instr.thread);
	chan_launch_c: cover property (launch && instr.thread);
	busy_refuse_c: cover property (busy && access && PWRITE && hit_cmd);
	unmapped_c: cover property (PSLVERR);

endmodule

// ### hdl/ddi_pkg.sv
/*
 * Constants, field layouts and carrier types for the debug instruction
 * register block.
 * Assumes a 32-bit register bus with word-aligned byte offsets.
 */
package ddi_pkg;

	// Register byte offsets within the block's window.
	localparam logic [11:0] OFF_STATUS   = 12'h000; // Debug status, read.
	localparam logic [11:0] OFF_COMMAND  = 12'h004; // Debug command, write.
	localparam logic [11:0] OFF_INSTR_LO = 12'h008; // debug_instr_low.
	localparam logic [11:0] OFF_INSTR_HI = 12'h00C; // debug_instr_high.
	localparam logic [11:0] OFF_CONFIG   = 12'h010; // config_report_zero.

	// Field positions of debug_instr_low.
	localparam int LO_BYTE1_MSB  = 31;
	localparam int LO_BYTE1_LSB  = 24;
	localparam int LO_BYTE0_MSB  = 23;
	localparam int LO_BYTE0_LSB  = 16;
	localparam int LO_CHAN_MSB   = 10;
	localparam int LO_CHAN_LSB   = 8;
	localparam int LO_THREAD_BIT = 0;

	// Field positions of config_report_zero.
	localparam int CFG_PERIPH_BIT  = 0;
	localparam int CFG_BOOT_EN_BIT = 1;
	localparam int CFG_MGR_NS_BIT  = 2;
	localparam int CFG_CHNLS_LSB   = 4;
	localparam int CFG_PERIPH_LSB  = 12;
	localparam int CFG_EVENTS_LSB  = 17;

	// Command codes and widths.
	localparam logic [1:0] CMD_EXECUTE = 2'h0; // Others are reserved.
	localparam int         NUM_CHAN    = 8;
	localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
	localparam logic [7:0]  CHAN_ONE   = 8'h01;

	// Dispatcher states.
	typedef enum logic {ST_IDLE, ST_BUSY} ddi_state_type;

	// Stored debug instruction and its target.
	typedef struct packed {
		logic [7:0] byte5;
		logic [7:0] byte4;
		logic [7:0] byte3;
		logic [7:0] byte2;
		logic [7:0] byte1;
		logic [7:0] byte0;
		logic [2:0] channel;
		logic       thread;
	} ddi_instr_type;

	// Tie-off configuration inputs.
	typedef struct packed {
		logic [4:0] num_events;
		logic [4:0] num_periph;
		logic       periph_en;
		logic [2:0] num_chnls;
	} ddi_tieoff_type;

endpackage

// ### dv/ddi_engine_model.sv
/*
 * Stand-in for the execution engine: answers each launch with one
 * EXEC_DONE pulse after a bench-set number of cycles.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps

module ddi_engine_model
(
	CLK,
	RST_B,
	EXEC_VALID,
	DELAY,
	EXEC_DONE
);
	input  wire logic       CLK;
	input  wire logic       RST_B;
	input  wire logic       EXEC_VALID;
	input  wire logic [7:0] DELAY;
	output logic            EXEC_DONE;

	logic [7:0] cnt; // Cycles left until done; zero when idle.

	// A zero delay finishes in the launch cycle itself, the fastest case.
	assign EXEC_DONE = (EXEC_VALID && DELAY == 8'h00) || cnt == 8'h01;

	// Reload on each launch, then count down to the done pulse.
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			cnt <= 8'h00;
		else if (EXEC_VALID)
			cnt <= DELAY;
		else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
	end
endmodule

// ### dv/test_ddi_regs.sv
/*
 * Self-checking bench for the debug instruction register bank.
 * Assumes zero-wait APB on a 50 ns clock and the engine stand-in.
 */
`timescale 1ns/1ps

module test_ddi_regs;
	logic                    clk = 1'h0;
	logic                    rst_b = 1'h0;
	logic                    psel = 1'h0;
	logic                    penable = 1'h0;
	logic                    pwrite = 1'h0;
	logic [11:0]             paddr = 12'h000;
	logic [31:0]             pwdata = 32'h0;
	logic [31:0]             prdata;
	logic                    pready;
	logic                    pslverr;
	ddi_pkg::ddi_tieoff_type tieoff = {5'h1A, 5'h0B, 1'h1, 3'h5};
	logic                    exec_valid;
	ddi_pkg::ddi_instr_type  exec_cmd;
	logic                    exec_mgr_sel;
	logic [7:0]              exec_chan_sel;
	logic                    exec_done;
	logic [7:0]              eng_delay = 8'h0C;
	int                      n_mismatch = 0;
	int                      n_tests = 0;

	// Free-running bus clock.
	always #25 clk = ~clk;

	ddi_regs dut_u (.CLK(clk), .RST_B(rst_b), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TIEOFF(tieoff), .BOOT_MGR_NS(1'h1),
		.BOOT_FROM_PC(1'h0), .EXEC_VALID(exec_valid),
		.EXEC_CMD(exec_cmd), .EXEC_MGR_SEL(exec_mgr_sel),
		.EXEC_CHAN_SEL(exec_chan_sel), .EXEC_DONE(exec_done));

	ddi_engine_model eng_u (.CLK(clk), .RST_B(rst_b),
		.EXEC_VALID(exec_valid), .DELAY(eng_delay),
		.EXEC_DONE(exec_done));

	////////////////////////////////////////////////////////////////////
	// Compare one value and report a mismatch at once.
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// One two-cycle APB transfer; the answer is taken at the rising
	// edge that ends the access cycle, where PREADY is sampled high.
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic err);
		@(posedge clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		q   = prdata;
		err = pslverr;
		chk(pready, 1'h1);
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	// Read and compare data and error flag.
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic ee);
		logic [31:0] q;
		logic        err;
		xfer(1'h0, a, 32'h0, q, err);
		chk(q, e);
		chk(err, ee);
	endtask

	// Write; the launch shows in the cycle after the returning edge.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        err;
		xfer(1'h1, a, d, q, err);
	endtask

	// Load (optionally), execute, check the launch, then wait for idle.
	task automatic run_instr(input logic [31:0] lo, input logic [31:0] hi,
		input logic load, input logic again);
		logic [31:0] q;
		logic        err;
		if (load)
		begin
			wr(ddi_pkg::OFF_INSTR_LO, lo);
			wr(ddi_pkg::OFF_INSTR_HI, hi);
		end
		wr(ddi_pkg::OFF_COMMAND, 32'h0);
		@(negedge clk);
		chk(exec_valid, 1'h1);
		chk(exec_cmd, {hi, lo[31:16], lo[10:8], lo[0]});
		chk(exec_mgr_sel, !lo[0]);
		chk(exec_chan_sel, lo[0] ? 8'h01 << lo[10:8] : 8'h00);
		// A second execute while busy must not launch.
		if (again)
		begin
			wr(ddi_pkg::OFF_COMMAND, 32'h0);
			@(negedge clk);
			chk(exec_valid, 1'h0);
		end
		xfer(1'h0, ddi_pkg::OFF_STATUS, 32'h0, q, err);
		if (eng_delay > 8'h08)
			chk(q[0], 1'h1);
		for (int i = 0; i < 50 && q[0] !== 1'h0; i++)
			xfer(1'h0, ddi_pkg::OFF_STATUS, 32'h0, q, err);
		chk(q[0], 1'h0);
	endtask

	// Print counts and verdict, then stop.
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// Main sequence: reset, reports, every channel, refusals.
	initial
	begin
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		rd(ddi_pkg::OFF_CONFIG, 32'h0034_B055, 1'h0);
		rd(12'h014, 32'h0, 1'h1);
		rd(ddi_pkg::OFF_INSTR_LO, 32'h0, 1'h0);
		for (int c = 0; c < 8; c++)
			run_instr({8'hB1, 8'hB0, 5'h0, 3'(c), 8'h01},
				{8'hB5, 8'hB4, 8'hB3, 8'(c)}, 1'h1, c == 3);
		eng_delay <= 8'h00;
		run_instr(32'h7E6D_0500, 32'h5A4B_3C2D, 1'h1, 1'h0);
		eng_delay <= 8'h0C;
		run_instr(32'h7E6D_0500, 32'h5A4B_3C2D, 1'h0, 1'h0);
		// Reserved command codes launch nothing.
		for (int c = 1; c < 4; c++)
		begin
			wr(ddi_pkg::OFF_COMMAND, 32'(c));
			@(negedge clk);
			chk(exec_valid, 1'h0);
		end
		wrap_up();
	end

	// Watchdog well beyond the expected run length.
	initial
	begin
		#1000000;
		n_mismatch++;
		wrap_up();
	end
endmodule
